/* File: logic/port_four_pkg.sv */
// Package: register map, field layout and reset values of the four-pin port
package port_four_pkg;
    // ========================================
    // Register indices (byte address = index * 4)
    localparam logic [15:0] IDX_PORT_FOUR_DATA = 16'hffd7;
    localparam logic [15:0] IDX_PORT_FOUR_DIRECTION = 16'hffe7;
    localparam logic [15:0] IDX_PIN_MODE_SELECT = 16'hfff0;
    localparam logic [15:0] IDX_POWER_MODE = 16'hfff1;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 17;

    // ========================================
    // Reset values and fixed read values
    localparam logic [7:0] RST_PORT_FOUR_DATA = 8'hf8;
    localparam logic [7:0] RST_PORT_FOUR_DIRECTION = 8'hf8;
    localparam logic [7:0] RST_PIN_MODE_SELECT = 8'h00;
    localparam logic [7:0] DIRECTION_READ_VALUE = 8'hff;
    localparam logic [3:0] DATA_UPPER_READ = 4'hf;

    // ========================================
    // Pin mode select fields
    localparam int FLD_IRQ_PIN_SELECT = 0;
    localparam int FLD_TRANSMITTER_ENABLE = 1;
    localparam int FLD_RECEIVER_ENABLE = 2;
    localparam int FLD_TRANSMIT_PIN_ENABLE = 3;
    localparam int FLD_CLOCK_ENABLE_ZERO = 4;
    localparam int FLD_CLOCK_ENABLE_ONE = 5;
    localparam int FLD_SYNC_MODE_SELECT = 6;
    localparam int MODE_SELECT_WIDTH = 7;

    // ========================================
    // Pin positions
    localparam int PIN_CLOCK = 0;
    localparam int PIN_RX = 1;
    localparam int PIN_TX = 2;
    localparam int PIN_IRQ = 3;
    localparam int GPIO_PINS = 3;
    localparam int ALL_PINS = 4;

    // ========================================
    // Operating modes
    typedef enum logic [2:0] {
        PM_ACTIVE,
        PM_SUBACTIVE,
        PM_SLEEP,
        PM_SUBSLEEP,
        PM_WATCH,
        PM_STANDBY
    } power_mode_t;
    localparam logic [2:0] RST_POWER_MODE = 3'h0;
endpackage

/* File: logic/pin_sync_if.sv */
// Interface: raw pin levels in, synchronised pin levels out
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int WIDTH = 4);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface
`default_nettype wire

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Async reset, active high
    pin_sync_if.sync_side sio // Raw and synchronised levels
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync width must be at least one");
        end
    endgenerate

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= sio.raw;
            sync_ff <= meta_ff;
        end
    end

    assign sio.synced = sync_ff;
endmodule
`default_nettype wire

/* File: logic/port_four.sv */
// Four-pin port with serial and interrupt multiplexing, Wishbone register slave
//
// Functional notes
// [RULE_01] Pins 2..0 are bidirectional, pin 3 is input only.
// [RULE_02] Data register resets to f8; bits 7..4 read one, bit 3 read-only.
// [RULE_03] Output-direction bits read stored data; input-direction bits read the pin.
// [RULE_04] Direction bit one makes the pin an output, zero an input.
// [RULE_05] Direction register is write-only and always reads all ones.
// [RULE_06] Direction register resets to f8, making pins 2..0 inputs.
// [RULE_07] Data and direction act only while the pin is general-purpose.
// [RULE_08] Pin 3 is plain input, or interrupt request when select bit set.
// [RULE_09] Pin 2 drives transmit data when pin-enable and transmitter-enable both set.
// [RULE_10] Pin 1 is receive input when receiver enable is set.
// [RULE_11] Pin 0: clock in if enable one, clock out if enable zero or sync.
// [RULE_12] Pins float in reset and standby, hold in sleep modes, else work; the code works them only in active and subactive, and holds them in watch.
// [RULE_13] Writes to upper and input-only data bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module port_four
    import port_four_pkg::*;
(
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic reset, // Async reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [31:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic [3:0] pin_in, // Pin levels from pads
    output logic [2:0] pin_out, // Pin drive levels
    output logic [2:0] pin_oe_n, // Pin output enables, low drives
    input wire logic serial_tx_out, // Transmit data from serial channel
    input wire logic serial_clock_out, // Clock from serial channel
    output logic serial_rx_in, // Receive data to serial channel
    output logic serial_clock_pin, // Clock from pin to serial channel
    output logic irq_req_n // Interrupt request level, low active
);
    // ========================================
    // Pin synchroniser
    pin_sync_if #(.WIDTH(ALL_PINS)) sio ();
    assign sio.raw = pin_in;

    pin_sync #(.WIDTH(ALL_PINS)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .sio(sio)
    );

    wire logic [3:0] pin_lvl = sio.synced;

    // ========================================
    // Register decode
    function automatic logic reg_hit(input logic [31:0] adr, input logic [15:0] idx);
        reg_hit = (adr[IDX_MSB:IDX_LSB] == idx) && (adr[31:IDX_MSB+1] == '0);
    endfunction

    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr_en = req && wb_we_i && wb_sel_i[0];
    wire logic hit_data = reg_hit(wb_adr_i, IDX_PORT_FOUR_DATA);
    wire logic hit_dir = reg_hit(wb_adr_i, IDX_PORT_FOUR_DIRECTION);
    wire logic hit_mode = reg_hit(wb_adr_i, IDX_PIN_MODE_SELECT);
    wire logic hit_pm = reg_hit(wb_adr_i, IDX_POWER_MODE);

    // ========================================
    // Registers
    logic [2:0] data_ff;
    logic [2:0] dir_ff;
    logic [MODE_SELECT_WIDTH-1:0] mode_ff;
    logic [2:0] pm_ff;
    logic ack_ff;
    logic [7:0] rd_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            data_ff <= RST_PORT_FOUR_DATA[2:0]; // [RULE_02]
            dir_ff <= RST_PORT_FOUR_DIRECTION[2:0]; // [RULE_06]
            mode_ff <= RST_PIN_MODE_SELECT[MODE_SELECT_WIDTH-1:0];
            pm_ff <= RST_POWER_MODE;
        end else if (wr_en) begin
            // Data and direction store only bits 2..0; upper and pin-3 bits are dropped
            if (hit_data) begin
                data_ff <= wb_dat_i[2:0]; // [RULE_13]
            end
            if (hit_dir) begin
                dir_ff <= wb_dat_i[2:0]; // [RULE_04]
            end
            if (hit_mode) begin
                mode_ff <= wb_dat_i[MODE_SELECT_WIDTH-1:0];
            end
            if (hit_pm) begin
                pm_ff <= wb_dat_i[2:0];
            end
        end
    end

    // ========================================
    // Mode decode
    wire logic irq_sel = mode_ff[FLD_IRQ_PIN_SELECT];
    wire logic te = mode_ff[FLD_TRANSMITTER_ENABLE];
    wire logic re = mode_ff[FLD_RECEIVER_ENABLE];
    wire logic tpe = mode_ff[FLD_TRANSMIT_PIN_ENABLE];
    wire logic clock_enable_bit_zero = mode_ff[FLD_CLOCK_ENABLE_ZERO];
    wire logic clock_enable_bit_one = mode_ff[FLD_CLOCK_ENABLE_ONE];
    wire logic sync_sel = mode_ff[FLD_SYNC_MODE_SELECT];

    wire logic tx_sel = tpe && te; // [RULE_09]
    wire logic clk_in_sel = clock_enable_bit_one; // [RULE_11]
    wire logic clk_out_sel = !clock_enable_bit_one && (clock_enable_bit_zero || sync_sel); // [RULE_11]

    // Pins still under data and direction control
    wire logic [2:0] gpio_sel = {!tx_sel, !re, !(clk_in_sel || clk_out_sel)}; // [RULE_07]
    wire logic [2:0] dir_eff = dir_ff & gpio_sel; // [RULE_07]

    wire power_mode_t pm = power_mode_t'(pm_ff);
    wire logic pm_run = (pm == PM_ACTIVE) || (pm == PM_SUBACTIVE);
    wire logic pm_float = (pm == PM_STANDBY);

    // ========================================
    // Pin drive
    logic [2:0] nxt_drive;
    logic [2:0] nxt_level;

    always_comb begin
        nxt_drive = dir_eff; // [RULE_04]
        nxt_level = data_ff;
        if (tx_sel) begin
            nxt_drive[PIN_TX] = 1'b1; // [RULE_09]
            nxt_level[PIN_TX] = serial_tx_out;
        end
        if (clk_out_sel) begin
            nxt_drive[PIN_CLOCK] = 1'b1; // [RULE_11]
            nxt_level[PIN_CLOCK] = serial_clock_out;
        end
    end

    logic [2:0] pin_out_ff;
    logic [2:0] pin_oe_n_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_out_ff <= '0;
            pin_oe_n_ff <= '1; // [RULE_12]
        end else if (pm_float) begin
            pin_oe_n_ff <= '1; // [RULE_12]
        end else if (pm_run) begin
            pin_out_ff <= nxt_level;
            pin_oe_n_ff <= ~nxt_drive; // [RULE_01]
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe_n = pin_oe_n_ff;

    // ========================================
    // Serial and interrupt routing
    assign serial_rx_in = re ? pin_lvl[PIN_RX] : 1'b1; // [RULE_10]
    assign serial_clock_pin = clk_in_sel ? pin_lvl[PIN_CLOCK] : 1'b0; // [RULE_11]
    assign irq_req_n = irq_sel ? pin_lvl[PIN_IRQ] : 1'b1; // [RULE_08]

    // ========================================
    // Read path
    wire logic [2:0] gpio_rd;

    genvar gi;
    generate
        for (gi = 0; gi < GPIO_PINS; gi++) begin : g_rd
            assign gpio_rd[gi] = dir_eff[gi] ? data_ff[gi] : pin_lvl[gi]; // [RULE_03]
        end
    endgenerate

    wire logic [7:0] data_rd = {DATA_UPPER_READ, pin_lvl[PIN_IRQ], gpio_rd}; // [RULE_02]

    logic [7:0] nxt_rd;

    always_comb begin
        nxt_rd = 8'h00;
        if (hit_data) begin
            nxt_rd = data_rd;
        end else if (hit_dir) begin
            nxt_rd = DIRECTION_READ_VALUE; // [RULE_05]
        end else if (hit_mode) begin
            nxt_rd = {1'b0, mode_ff};
        end else if (hit_pm) begin
            nxt_rd = {5'h00, pm_ff};
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rd_ff <= 8'h00;
        end else begin
            ack_ff <= req;
            if (req && !wb_we_i) begin
                rd_ff <= nxt_rd;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = {24'h000000, rd_ff};

    // ========================================
    // Assertions
    sequence s_read_dir;
        req && !wb_we_i && hit_dir;
    endsequence

    sequence s_read_data;
        req && !wb_we_i && hit_data;
    endsequence

    property p_dir_reads_ones;
        @(posedge clk_sys) disable iff (reset)
        s_read_dir |=> wb_ack_o && (wb_dat_o[7:0] == 8'hff);
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) // [RULE_05]
        else $error("direction read not all ones");

    property p_data_upper_ones;
        @(posedge clk_sys) disable iff (reset)
        s_read_data |=> (wb_dat_o[7:4] == 4'hf) && (wb_dat_o[3] == $past(pin_lvl[3]));
    endproperty
    a_data_upper_ones: assert property (p_data_upper_ones) // [RULE_02]
        else $error("data upper bits wrong");

    property p_read_output_bit;
        @(posedge clk_sys) disable iff (reset)
        s_read_data ##0 dir_eff[2] |=> wb_dat_o[2] == $past(data_ff[2]);
    endproperty
    a_read_output_bit: assert property (p_read_output_bit) // [RULE_03]
        else $error("output bit not read from store");

    property p_gpio_drive;
        @(posedge clk_sys) disable iff (reset)
        pm_run && dir_ff[1] && !re |=> !pin_oe_n[1] && (pin_out[1] == $past(data_ff[1]));
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) // [RULE_04]
        else $error("pin 1 output not driven");

    property p_tx_drive;
        @(posedge clk_sys) disable iff (reset)
        pm_run && tpe && te |=> !pin_oe_n[2] && (pin_out[2] == $past(serial_tx_out));
    endproperty
    a_tx_drive: assert property (p_tx_drive) // [RULE_09]
        else $error("transmit data not on pin 2");

    property p_rx_input;
        @(posedge clk_sys) disable iff (reset)
        pm_run && re |=> pin_oe_n[1];
    endproperty
    a_rx_input: assert property (p_rx_input) // [RULE_10]
        else $error("pin 1 driven while receiving");

    property p_clock_in;
        @(posedge clk_sys) disable iff (reset)
        pm_run && clock_enable_bit_one |=> pin_oe_n[0];
    endproperty
    a_clock_in: assert property (p_clock_in) // [RULE_11]
        else $error("pin 0 driven while clock input");

    property p_clock_out;
        @(posedge clk_sys) disable iff (reset)
        pm_run && !clock_enable_bit_one && (clock_enable_bit_zero || sync_sel)
            |=> !pin_oe_n[0] && (pin_out[0] == $past(serial_clock_out));
    endproperty
    a_clock_out: assert property (p_clock_out) // [RULE_11]
        else $error("serial clock not on pin 0");

    property p_standby_float;
        @(posedge clk_sys) disable iff (reset)
        pm_float |=> pin_oe_n == 3'b111;
    endproperty
    a_standby_float: assert property (p_standby_float) // [RULE_12]
        else $error("pins driven in standby");

    property p_sleep_hold;
        @(posedge clk_sys) disable iff (reset)
        !pm_run && !pm_float |=> $stable(pin_oe_n) && $stable(pin_out);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) // [RULE_12]
        else $error("pins changed while held");

    property p_irq_plain;
        @(posedge clk_sys) disable iff (reset)
        irq_req_n == (irq_sel ? $past(pin_in[PIN_IRQ], 2) : 1'b1);
    endproperty
    a_irq_plain: assert property (p_irq_plain) // [RULE_08]
        else $error("interrupt level does not follow pin 3");

    property p_rx_follow;
        @(posedge clk_sys) disable iff (reset)
        serial_rx_in == (re ? $past(pin_in[PIN_RX], 2) : 1'b1);
    endproperty
    a_rx_follow: assert property (p_rx_follow) // [RULE_10]
        else $error("receive input does not follow pin 1");

    property p_clock_follow;
        @(posedge clk_sys) disable iff (reset)
        serial_clock_pin == (clk_in_sel ? $past(pin_in[PIN_CLOCK], 2) : 1'b0);
    endproperty
    a_clock_follow: assert property (p_clock_follow) // [RULE_11]
        else $error("clock input does not follow pin 0");
endmodule
`default_nettype wire

/* File: tb/pad_model.sv */
// Pad model: far-side levels meet the port's drivers
`timescale 1ns/1ps
`default_nettype none
module pad_model (
    input wire logic [2:0] pin_out, // Port drive levels
    input wire logic [2:0] pin_oe_n, // Port enables, low drives
    input wire logic [3:0] ext_lvl, // Level the far side applies
    output logic [3:0] pin_in // Resolved pad levels
);
    // Released pads take the far level, driven pads the port's
    always_comb begin
        pin_in[3] = ext_lvl[3];
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_port_four.sv */
// Self-checking bench for the four-pin port
`timescale 1ns/1ps
`default_nettype none
module tb_port_four
    import port_four_pkg::*;
;
    logic clk_sys, reset, cyc, stb, we, ack, tx, ck, rx_in, ck_pin, irq_n;
    logic [31:0] adr, wdat, rdat, q, r;
    logic [3:0] sel, ext, pin_in;
    logic [2:0] pout, poe_n, held;
    logic [6:0] m;
    logic [31:0] seed = 32'he759aa19;
    logic [6:0] tab [10] = '{7'h00, 7'h01, 7'h02, 7'h0a, 7'h04, 7'h10, 7'h20, 7'h40, 7'h30, 7'h7f};
    power_mode_t pmt [7] = '{PM_ACTIVE, PM_SLEEP, PM_SUBACTIVE, PM_SUBSLEEP, PM_WATCH,
        PM_STANDBY, PM_ACTIVE};
    int n_fail, n_compared;

    port_four dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pin_in(pin_in), .pin_out(pout), .pin_oe_n(poe_n),
        .serial_tx_out(tx), .serial_clock_out(ck), .serial_rx_in(rx_in),
        .serial_clock_pin(ck_pin), .irq_req_n(irq_n));
    pad_model u_pad (.pin_out(pout), .pin_oe_n(poe_n), .ext_lvl(ext), .pin_in(pin_in));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ========================================
    // Random source and expectation functions
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] fn_ser(input logic [6:0] md);
        return {md[3] & md[1], md[2], md[5] | md[4] | md[6]};
    endfunction
    function automatic logic [2:0] fn_oe_n(input logic [6:0] md, input logic [2:0] d);
        logic [2:0] s;
        s = fn_ser(md);
        return (~s & ~d) | (s & {1'b0, 1'b1, md[5]});
    endfunction
    function automatic logic [2:0] fn_out(input logic [6:0] md, input logic [2:0] v);
        return (fn_ser(md) & {tx, 1'b0, ck}) | (~fn_ser(md) & v);
    endfunction
    function automatic logic [7:0] fn_rd(input logic [6:0] md, input logic [2:0] d,
        input logic [2:0] v);
        logic [2:0] oe, lvl, g;
        oe = fn_oe_n(md, d);
        lvl = (oe & ext[2:0]) | (~oe & fn_out(md, v));
        g = ~fn_ser(md) & d;
        return {4'hf, ext[3], (g & v) | (~g & lvl)};
    endfunction

    // ========================================
    // Compare, bus and closing tasks
    task automatic test_done();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t pins got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {14'h0, idx, 2'b00};
        wdat <= {r[31:8], d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            $display("mismatch t=%0t no acknowledge", $time);
            test_done();
        end
    endtask
    task automatic check(input logic [6:0] md, input logic [2:0] d, input logic [2:0] v);
        logic [2:0] oe;
        oe = fn_oe_n(md, d);
        cmp_pin({1'b0, poe_n}, {1'b0, oe});
        cmp_pin({1'b0, pout & ~oe}, {1'b0, fn_out(md, v) & ~oe});
        cmp_pin({1'b0, rx_in, ck_pin, irq_n},
            {1'b0, md[2] ? ext[1] : 1'b1, md[5] & ext[0], md[0] ? ext[3] : 1'b1});
        bus(1'b0, IDX_PORT_FOUR_DATA, 8'h00);
        cmp_reg(q, {24'h0, fn_rd(md, d, v)});
        bus(1'b0, IDX_PORT_FOUR_DIRECTION, 8'h00);
        cmp_reg(q, 32'hff);
    endtask

    // ========================================
    // Main sequence
    initial begin
        {reset, cyc, stb, we, tx, ck} = 6'h20;
        {adr, wdat, r} = '0;
        sel = 4'hf;
        ext = 4'ha;
        n_fail = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_sys);
        cmp_pin({1'b0, poe_n}, 4'h7);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(7'h00, 3'h0, 3'h0);
        $display("test reset values done");
        for (int i = 0; i < 40; i++) begin
            r = xs();
            m = (i < 10) ? tab[i] : r[6:0];
            bus(1'b1, IDX_PIN_MODE_SELECT, {1'b0, m});
            bus(1'b1, IDX_PORT_FOUR_DIRECTION, r[15:8]);
            bus(1'b1, IDX_PORT_FOUR_DATA, r[23:16]);
            ext <= r[27:24];
            tx <= r[28];
            ck <= r[29];
            repeat (4) @(posedge clk_sys);
            check(m, r[10:8], r[18:16]);
        end
        $display("test pin functions done");
        bus(1'b1, 16'h1234, 8'h55);
        bus(1'b0, 16'h1234, 8'h00);
        cmp_reg(q, 32'h0);
        $display("test unmapped done");
        bus(1'b1, IDX_PIN_MODE_SELECT, 8'h00);
        bus(1'b1, IDX_PORT_FOUR_DIRECTION, 8'h07);
        held = 3'h0;
        for (int i = 0; i < 7; i++) begin
            r = xs();
            bus(1'b1, IDX_POWER_MODE, {5'h0, pmt[i]});
            bus(1'b1, IDX_PORT_FOUR_DATA, r[7:0]);
            repeat (4) @(posedge clk_sys);
            if (pmt[i] == PM_ACTIVE || pmt[i] == PM_SUBACTIVE) begin
                held = r[2:0];
            end
            cmp_pin({1'b0, poe_n}, (pmt[i] == PM_STANDBY) ? 4'h7 : 4'h0);
            if (pmt[i] != PM_STANDBY) begin
                cmp_pin({1'b0, pout}, {1'b0, held});
            end
        end
        sel <= 4'he;
        bus(1'b1, IDX_PORT_FOUR_DATA, {5'h00, ~held});
        sel <= 4'hf;
        repeat (4) @(posedge clk_sys);
        cmp_pin({1'b0, pout}, {1'b0, held});
        bus(1'b0, IDX_PORT_FOUR_DATA, 8'h00);
        cmp_reg(q, {24'h0, 4'hf, ext[3], held});
        $display("test power modes done");
        test_done();
    end
endmodule
`default_nettype wire
